// *** bench/rsma_checker.sv ***
`timescale 1ns/10ps
module rsma_checker(
  input wire clk_i,
  input wire srst_i,
  input wire run_switch_i,
  input wire wr_i,
  input wire rd_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire [31:0] rdata_o,
  input wire running_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_go;
    wr_i && addr_i == 4'h0 && wdata_i[8] && !wdata_i[9];
  endsequence
  sequence s_sw;
    $rose(run_switch_i) ##0 (run_switch_i && !wr_i)[*6];
  endsequence
  sequence s_rdstat;
    rd_i && addr_i == 4'h1;
  endsequence
  AST_PWRUP: assert property ($fell(srst_i) |-> !running_o ##1 !running_o)
    else $error("running right after reset");
  AST_STAT: assert property (s_rdstat |=> rdata_o[0] == $past(running_o))
    else $error("status run bit wrong");
  AST_RUN: assert property (s_go |-> ##2 running_o)
    else $error("remote run lost");
  AST_STOP: assert property (wr_i && addr_i == 4'h0 && wdata_i[9]
    |-> ##2 !running_o) else $error("remote stop lost");
  AST_SW: assert property (s_sw |-> running_o)
    else $error("switch run ignored");
  AST_RST: assert property (@(posedge clk_i) disable iff (1'b0)
    srst_i |=> !running_o && rdata_o == 32'h0)
    else $error("reset state wrong");
endmodule // rsma_checker
bind rsma_arbiter rsma_checker chk_u (.*);

// *** bench/rsma_operator.sv ***
`timescale 1ns/10ps
module rsma_operator(
  input wire clk_i,
  input wire sw_i,
  input wire [4:0] pin_i,
  output reg run_switch_o,
  output reg [15:0] general_input_o
);
  // No pushbutton flags, no cassette writes here
  // At most one general input high at a time
  always @(posedge clk_i) begin
    run_switch_o <= sw_i;
    general_input_o <= {15'h0, pin_i[4]} << pin_i[3:0];
  end
endmodule // rsma_operator

// *** bench/tb.sv ***
`timescale 1ns/10ps
module tb;
  reg clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, sw = 0;
  reg [4:0] pin = 0;
  reg [3:0] addr_i = 0;
  reg [31:0] wdata_i = 0;
  wire sw_q, running_o, running_s;
  reg [31:0] q;
  wire [15:0] gin;
  wire [31:0] rdata_o;
  integer n_errors = 0, n_compared = 0;
  always #4 clk_i = ~clk_i;
  rsma_operator op_u(.clk_i(clk_i), .sw_i(sw), .pin_i(pin),
    .run_switch_o(sw_q), .general_input_o(gin));
  rsma_arbiter dut_u(.clk_i(clk_i), .srst_i(srst_i), .run_switch_i(sw_q),
    .general_input_i(gin), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .running_o(running_o));
  rsma_arbiter #(.SMALL_UNIT(1)) dut_s_u(.clk_i(clk_i), .srst_i(srst_i),
    .run_switch_i(sw_q), .general_input_i(gin), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(),
    .running_o(running_s));
  // ==========
  // Helpers
  task chk(input [31:0] g, input [31:0] e); begin
    n_compared = n_compared + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  end endtask
  task cyc(input integer n); begin repeat (n) @(posedge clk_i); #1; end
  endtask
  task wr(input [31:0] d); begin
    @(posedge clk_i); wr_i <= 1; wdata_i <= d; addr_i <= 4'h0;
    @(posedge clk_i); wr_i <= 0;
  end endtask
  task rd(input [3:0] a, output [31:0] d); begin
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    #1;
    d = rdata_o;
  end endtask
  // ==========
  // Scenarios
  task t_switch; begin
    @(posedge clk_i) sw <= 1;
    cyc(8);
    chk(running_o, 1);
    @(posedge clk_i) sw <= 0;
    cyc(8);
    chk(running_o, 0);
  end endtask
  task t_select; begin
    wr(32'h0000000F);
    rd(4'h0, q);
    chk(q, 32'h0000000F);
    @(posedge clk_i) pin <= 5'h1F;
    cyc(8);
    chk(running_o, 1);
    chk(running_s, 0);
    @(posedge clk_i) pin <= 5'h17;
    cyc(8);
    chk(running_o, 0);
    chk(running_s, 1);
    @(posedge clk_i) pin <= 5'h1E;
    cyc(8);
    chk(running_o, 0);
    @(posedge clk_i) pin <= 0;
    cyc(8);
  end endtask
  task t_remote; begin
    wr(32'h00000100);
    cyc(1);
    chk(running_o, 1);
    wr(32'h00000300);
    cyc(1);
    chk(running_o, 0);
  end endtask
  task t_resume; begin
    @(posedge clk_i) sw <= 1;
    cyc(8);
    chk(running_o, 1);
    wr(32'h00000200);
    cyc(1);
    chk(running_o, 0);
    rd(4'h1, q);
    chk(q, 32'h0000001A);
    @(posedge clk_i) sw <= 0;
    cyc(8);
    chk(running_o, 0);
    @(posedge clk_i) sw <= 1;
    cyc(8);
    chk(running_o, 1);
  end endtask
  task t_reset; begin
    @(posedge clk_i) sw <= 0;
    wr(32'h00000100);
    cyc(8);
    chk(running_o, 1);
    @(posedge clk_i) srst_i <= 1;
    cyc(2);
    @(posedge clk_i) srst_i <= 0;
    cyc(3);
    chk(running_o, 0);
    rd(4'h1, q);
    chk(q, 32'h00000000);
  end endtask
  task wrap_up; begin
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  end endtask
  initial begin #100000; n_errors = n_errors + 1; wrap_up; end
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 0;
    cyc(2);
    t_switch;
    t_select;
    t_remote;
    t_resume;
    t_reset;
    wrap_up;
  end
endmodule // tb

// *** design/rsma_arbiter.v ***
`timescale 1ns/10ps
`include "rsma_defines.vh"
module rsma_arbiter #(
  parameter NUM_INPUTS = 16,
  parameter SMALL_UNIT = 0
) (
  input wire clk_i,
  input wire srst_i,
  input wire run_switch_i,
  input wire [NUM_INPUTS-1:0] general_input_i,
  input wire [`RSMA_ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output reg running_o
);

  localparam SEL_W = 4;

  // ==========================================
  // Declarations
  reg sw_meta_r;
  reg sw_sync_r;
  reg sw_prev_r;
  reg in_prev_r;
  reg [SEL_W-1:0] sel_r;
  reg [SEL_W-1:0] sel_nxt;
  reg ovr_r;
  reg ovr_nxt;
  reg ovr_run_r;
  reg ovr_run_nxt;
  reg [31:0] ctrl_word;
  reg [31:0] stat_word;
  reg [31:0] rdata_nxt;
  wire [NUM_INPUTS-1:0] in_sync_w;
  wire [SEL_W-1:0] sel_eff;
  wire run_in;
  wire local_run;
  wire sw_rise;
  wire in_rise;
  wire local_go;
  wire ctrl_wr;
  wire rem_run;
  wire rem_stop;
  wire run_nxt;

  // ==========================================
  // Front switch synchroniser
  always @(posedge clk_i) begin
    if (srst_i) begin
      sw_meta_r <= 1'b0;
      sw_sync_r <= 1'b0;
    end else begin
      sw_meta_r <= run_switch_i;
      sw_sync_r <= sw_meta_r;
    end
  end

  // ==========================================
  // General input synchronisers
  // One flop pair per input, so any of the sixteen can be chosen later, the first eight on small units
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi = gi + 1) begin : g_in_sync
      reg meta_r;
      reg sync_r;

      always @(posedge clk_i) begin
        if (srst_i) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= general_input_i[gi];
          sync_r <= meta_r;
        end
      end

      assign in_sync_w[gi] = sync_r;
    end
  endgenerate

  // ==========================================
  // Run input selection
  // Small units reach only the first eight inputs
  assign sel_eff = SMALL_UNIT ? {1'b0, sel_r[2:0]} : sel_r;
  assign run_in = in_sync_w[sel_eff];
  assign local_run = sw_sync_r | run_in;

  // ==========================================
  // Stop-to-run edges of the local sources
  assign sw_rise = sw_sync_r & ~sw_prev_r;
  assign in_rise = run_in & ~in_prev_r;
  assign local_go = sw_rise | in_rise;

  always @(posedge clk_i) begin
    if (srst_i) begin
      sw_prev_r <= 1'b0;
      in_prev_r <= 1'b0;
    end else begin
      sw_prev_r <= sw_sync_r;
      // Follows the selected input: a new selection fakes an edge if the new input is high and the old one low
      in_prev_r <= run_in;
    end
  end

  // ==========================================
  // Command decode
  assign ctrl_wr = wr_i && (addr_i == `RSMA_REG_CTRL);
  assign rem_run = ctrl_wr && wdata_i[`RSMA_CTRL_RUN_BIT];
  assign rem_stop = ctrl_wr && wdata_i[`RSMA_CTRL_STOP_BIT];

  // ==========================================
  // Run input select register
  always @* begin
    sel_nxt = sel_r;
    if (ctrl_wr) begin
      sel_nxt = wdata_i[`RSMA_CTRL_SEL_MSB:`RSMA_CTRL_SEL_LSB];
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      sel_r <= `RSMA_SEL_RST;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // ==========================================
  // Remote override
  // Stop wins when both command bits come together; a command
  // also wins over a local edge in the same cycle.
  always @* begin
    ovr_nxt = ovr_r;
    ovr_run_nxt = ovr_run_r;
    if (rem_stop) begin
      ovr_nxt = 1'b1;
      ovr_run_nxt = 1'b0;
    end else if (rem_run) begin
      ovr_nxt = 1'b1;
      ovr_run_nxt = 1'b1;
    end else if (local_go) begin
      ovr_nxt = 1'b0;
      ovr_run_nxt = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      ovr_r <= 1'b0;
      ovr_run_r <= 1'b0;
    end else begin
      ovr_r <= ovr_nxt;
      ovr_run_r <= ovr_run_nxt;
    end
  end

  // ==========================================
  // Running state
  assign run_nxt = ovr_r ? ovr_run_r : local_run;

  always @(posedge clk_i) begin
    if (srst_i) begin
      running_o <= 1'b0;
    end else begin
      running_o <= run_nxt;
    end
  end

  // ==========================================
  // Read words
  always @* begin
    ctrl_word = 32'h00000000;
    ctrl_word[`RSMA_CTRL_SEL_MSB:`RSMA_CTRL_SEL_LSB] = sel_r;
    stat_word = 32'h00000000;
    stat_word[`RSMA_STAT_RUN_BIT] = running_o;
    stat_word[`RSMA_STAT_OVR_BIT] = ovr_r;
    stat_word[`RSMA_STAT_OVRRUN_BIT] = ovr_run_r;
    stat_word[`RSMA_STAT_LOCAL_BIT] = local_run;
    stat_word[`RSMA_STAT_SW_BIT] = sw_sync_r;
    stat_word[`RSMA_STAT_IN_BIT] = run_in;
  end

  // ==========================================
  // Read port
  // Data stand one cycle only, zero otherwise
  always @* begin
    rdata_nxt = 32'h00000000;
    if (rd_i) begin
      case (addr_i)
        `RSMA_REG_CTRL: begin
          rdata_nxt = ctrl_word;
        end
        `RSMA_REG_STAT: begin
          rdata_nxt = stat_word;
        end
        default: begin
          rdata_nxt = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

endmodule // rsma_arbiter

// *** design/rsma_defines.vh ***
// Notes on behaviour
// - Front switch run/stop sets running state
// - Control register picks run input among sixteen, eight on small units
// - Run input on gives running unless a remote override holds
// - Remote run/stop commands force state
// - Power-up clears any remote override
// - Local stop-then-run or remote run resumes
`ifndef RSMA_DEFINES_VH
`define RSMA_DEFINES_VH
// ==========================================
// Register map
`define RSMA_ADDR_W 4
`define RSMA_REG_CTRL 4'h0
`define RSMA_REG_STAT 4'h1
// ==========================================
// Control fields
`define RSMA_CTRL_SEL_LSB 0
`define RSMA_CTRL_SEL_MSB 3
`define RSMA_CTRL_RUN_BIT 8
`define RSMA_CTRL_STOP_BIT 9
`define RSMA_SEL_RST 4'h0
// ==========================================
// Status fields
`define RSMA_STAT_RUN_BIT 0
`define RSMA_STAT_OVR_BIT 1
`define RSMA_STAT_OVRRUN_BIT 2
`define RSMA_STAT_LOCAL_BIT 3
`define RSMA_STAT_SW_BIT 4
`define RSMA_STAT_IN_BIT 5
`endif
